// File: rtl/uef_endpoint.sv
// endpoint fifo transfer engine between serial engine and firmware
// Function
// - iso failures never retried, others kept for resend
// - valid IN shifts queued packet out
// - non-iso IN without ready packet answered with NAK
// - non-iso transmit done after host handshake
// - iso transmit: no handshake, status at frame end
// - one iso packet per frame per direction
// - tx control bit 3 selects iso transmit
// - non-iso handshake decides data sequence toggle
// - tx control bit 2 selects automatic read marker
// - manual mode: advance marker, rewind read pointer
// - start-of-frame starts iso transmit cycle
// - non-iso OUT data stored, then handshake returned
// - receive done raised after each non-iso receive
// - iso receive: no handshake, status at SOF
// - rx control bit 3 selects iso receive
// - non-iso receive checks data sequence bit
// - rx control bit 2 selects automatic write marker
// - manual mode: advance marker, rewind write pointer
//
// Added by the designer: the plain strobed port and the register offsets.
module uef_endpoint
   import uef_pkg::*;
#(
   parameter int DEPTH = 64
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // tokens from the serial engine
   input wire logic tok_valid,
   input wire logic tok_pid_ok,
   input wire logic [1:0] tok_kind,
   // transmit byte stream
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_accept,
   output logic tx_eop,
   output logic tx_seq,
   // handshake returned by the host
   input wire logic hs_in_valid,
   input wire logic hs_in_ack,
   // receive byte stream
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   input wire logic rx_good,
   input wire logic rx_seq,
   // handshake sent to the host
   output logic hs_out_ack,
   output logic hs_out_nak
);
   import uef_pkg::*;

   localparam int PW = $clog2(DEPTH) + 1;
   localparam logic [PW-1:0] PTR_ONE = PW'(1);
   localparam logic [PW-1:0] PTR_DEPTH = PW'(DEPTH);
   localparam logic [7:0] LEN_ONE = 8'h01;

   logic [7:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];

   uef_state_t state_reg, state_next;
   logic [3:0] tx_ctl_reg, tx_ctl_next;
   logic [3:0] rx_ctl_reg, rx_ctl_next;
   logic [PW-1:0] tx_wp_reg, tx_wp_next;
   logic [PW-1:0] tx_rm_reg, tx_rm_next;
   logic [PW-1:0] tx_rp_reg, tx_rp_next;
   logic [PW-1:0] rx_wp_reg, rx_wp_next;
   logic [PW-1:0] rx_wm_reg, rx_wm_next;
   logic [PW-1:0] rx_rp_reg, rx_rp_next;
   logic [7:0] tx_len_reg, tx_len_next;
   logic [7:0] tx_cnt_reg, tx_cnt_next;
   logic [7:0] rx_cnt_reg, rx_cnt_next;
   logic [7:0] rx_len_reg, rx_len_next;
   logic [7:0] status_reg, status_next;
   logic tx_seq_reg, tx_seq_next;
   logic rx_exp_reg, rx_exp_next;
   logic tx_iso_used_reg, tx_iso_used_next;
   logic rx_iso_used_reg, rx_iso_used_next;
   logic tx_iso_pend_reg, tx_iso_pend_next;
   logic rx_iso_pend_reg, rx_iso_pend_next;
   logic rx_iso_good_reg, rx_iso_good_next;
   logic rx_ovf_reg, rx_ovf_next;
   logic [7:0] tx_data_reg, tx_data_next;
   logic [7:0] rdata_reg, rdata_next;
   logic hs_ack_reg, hs_ack_next;
   logic hs_nak_reg, hs_nak_next;
   logic tx_mem_we, rx_mem_we;

   logic wr_tx_ctl, wr_rx_ctl, wr_tx_data, wr_tx_len, wr_status, rd_rx_data;
   logic tok_ok, sof_ok;
   logic tx_iso, tx_auto, rx_iso, rx_auto;
   logic tx_done_set, rx_done_set;
   logic tx_room, rx_room, rx_avail;

   assign wr_tx_ctl = reg_wr && (reg_addr == UEF_REG_TX_CTRL);
   assign wr_rx_ctl = reg_wr && (reg_addr == UEF_REG_RX_CTRL);
   assign wr_tx_data = reg_wr && (reg_addr == UEF_REG_TX_DATA);
   assign wr_tx_len = reg_wr && (reg_addr == UEF_REG_TX_LEN);
   assign wr_status = reg_wr && (reg_addr == UEF_REG_STATUS);
   assign rd_rx_data = reg_rd && (reg_addr == UEF_REG_RX_DATA);
   // only tokens with a good identifier count
   assign tok_ok = tok_valid && tok_pid_ok;
   assign sof_ok = tok_ok && (tok_kind == UEF_TOK_SOF);
   assign tx_iso = tx_ctl_reg[UEF_CTL_ISO];
   assign tx_auto = tx_ctl_reg[UEF_CTL_AUTO];
   assign rx_iso = rx_ctl_reg[UEF_CTL_ISO];
   assign rx_auto = rx_ctl_reg[UEF_CTL_AUTO];
   // firmware may not overrun the unsent region, hardware not the unread one
   assign tx_room = (tx_wp_reg - tx_rm_reg) != PTR_DEPTH;
   assign rx_room = (rx_wp_reg - rx_rp_reg) != PTR_DEPTH;
   assign rx_avail = rx_rp_reg != rx_wm_reg;

   assign tx_data = tx_data_reg;
   assign tx_valid = (state_reg == UEF_TX_SEND) && (tx_cnt_reg != tx_len_reg);
   assign tx_eop = (state_reg == UEF_TX_SEND) && (tx_cnt_reg == tx_len_reg);
   assign tx_seq = tx_seq_reg;
   assign hs_out_ack = hs_ack_reg;
   assign hs_out_nak = hs_nak_reg;
   assign reg_rdata = rdata_reg;

   always_comb begin
      state_next = state_reg;
      tx_ctl_next = tx_ctl_reg;
      rx_ctl_next = rx_ctl_reg;
      tx_wp_next = tx_wp_reg;
      tx_rm_next = tx_rm_reg;
      tx_rp_next = tx_rp_reg;
      rx_wp_next = rx_wp_reg;
      rx_wm_next = rx_wm_reg;
      rx_rp_next = rx_rp_reg;
      tx_len_next = tx_len_reg;
      tx_cnt_next = tx_cnt_reg;
      rx_cnt_next = rx_cnt_reg;
      rx_len_next = rx_len_reg;
      status_next = status_reg;
      tx_seq_next = tx_seq_reg;
      rx_exp_next = rx_exp_reg;
      tx_iso_used_next = tx_iso_used_reg;
      rx_iso_used_next = rx_iso_used_reg;
      tx_iso_pend_next = tx_iso_pend_reg;
      rx_iso_pend_next = rx_iso_pend_reg;
      rx_iso_good_next = rx_iso_good_reg;
      rx_ovf_next = rx_ovf_reg;
      hs_ack_next = 1'b0;
      hs_nak_next = 1'b0;
      tx_mem_we = 1'b0;
      rx_mem_we = 1'b0;
      tx_done_set = 1'b0;
      rx_done_set = 1'b0;
      rdata_next = UEF_BYTE_ZERO;

      // firmware side of the register port
      if (wr_tx_ctl) begin
         tx_ctl_next = {reg_wdata[UEF_CTL_ISO], reg_wdata[UEF_CTL_AUTO], 2'b00};
         if (!reg_wdata[UEF_CTL_AUTO] && reg_wdata[UEF_CTL_ADVANCE]) begin
            tx_rm_next = tx_rp_reg;
         end
         if (!reg_wdata[UEF_CTL_AUTO] && reg_wdata[UEF_CTL_REWIND]) begin
            tx_rp_next = tx_rm_reg;
         end
      end
      if (wr_rx_ctl) begin
         rx_ctl_next = {reg_wdata[UEF_CTL_ISO], reg_wdata[UEF_CTL_AUTO], 2'b00};
         if (!reg_wdata[UEF_CTL_AUTO] && reg_wdata[UEF_CTL_ADVANCE]) begin
            rx_wm_next = rx_wp_reg;
         end
         if (!reg_wdata[UEF_CTL_AUTO] && reg_wdata[UEF_CTL_REWIND]) begin
            rx_wp_next = rx_wm_reg;
         end
      end
      if (wr_tx_data && tx_room) begin
         tx_mem_we = 1'b1;
         tx_wp_next = tx_wp_reg + PTR_ONE;
      end
      if (wr_tx_len && (state_reg == UEF_IDLE)) begin
         tx_len_next = reg_wdata;
         status_next[UEF_ST_TX_READY] = 1'b1;
      end
      if (rd_rx_data && rx_avail) begin
         rx_rp_next = rx_rp_reg + PTR_ONE;
      end
      if (wr_status) begin
         status_next[UEF_ST_TX_DONE] = status_reg[UEF_ST_TX_DONE] & ~reg_wdata[UEF_ST_TX_DONE];
         status_next[UEF_ST_RX_DONE] = status_reg[UEF_ST_RX_DONE] & ~reg_wdata[UEF_ST_RX_DONE];
      end
      if (reg_rd) begin
         case (reg_addr)
            UEF_REG_TX_CTRL: rdata_next = {4'h0, tx_ctl_reg};
            UEF_REG_RX_CTRL: rdata_next = {4'h0, rx_ctl_reg};
            UEF_REG_TX_LEN: rdata_next = tx_len_reg;
            UEF_REG_RX_DATA: rdata_next = rx_avail ? rx_mem[rx_rp_reg[PW-2:0]] : UEF_BYTE_ZERO;
            UEF_REG_STATUS: rdata_next = status_reg;
            UEF_REG_RX_LEN: rdata_next = rx_len_reg;
            default: rdata_next = UEF_BYTE_ZERO;
         endcase
      end

      // frame boundary: settle iso status of the past frame
      if (sof_ok) begin
         tx_iso_used_next = 1'b0;
         rx_iso_used_next = 1'b0;
         if (tx_iso_pend_reg) begin
            tx_iso_pend_next = 1'b0;
            status_next[UEF_ST_TX_ACK] = 1'b1;
            status_next[UEF_ST_TX_ERR] = 1'b0;
            status_next[UEF_ST_TX_READY] = wr_tx_len && state_reg == UEF_IDLE;
            if (tx_auto) begin
               tx_rm_next = tx_rp_reg;
            end
         end
         if (rx_iso_pend_reg) begin
            rx_iso_pend_next = 1'b0;
            status_next[UEF_ST_RX_ACK] = rx_iso_good_reg;
            status_next[UEF_ST_RX_ERR] = !rx_iso_good_reg;
            status_next[UEF_ST_RX_OVF] = rx_ovf_reg;
            if (rx_auto) begin
               // a bad iso packet is dropped, never asked for again
               if (rx_iso_good_reg) begin
                  rx_wm_next = rx_wp_reg;
               end else begin
                  rx_wp_next = rx_wm_reg;
               end
            end
         end
      end

      case (state_reg)
         UEF_IDLE: begin
            if (tok_ok && (tok_kind == UEF_TOK_IN)) begin
               if (tx_iso) begin
                  // iso data goes out once per frame, sent only if armed
                  if (status_reg[UEF_ST_TX_READY] && !tx_iso_used_reg) begin
                     tx_iso_used_next = 1'b1;
                     tx_iso_pend_next = 1'b1;
                     tx_cnt_next = UEF_BYTE_ZERO;
                     state_next = UEF_TX_SEND;
                  end
               end else if (status_reg[UEF_ST_TX_READY]) begin
                  tx_cnt_next = UEF_BYTE_ZERO;
                  state_next = UEF_TX_SEND;
               end else begin
                  hs_nak_next = 1'b1;
               end
            end else if (tok_ok && (tok_kind == UEF_TOK_OUT)) begin
               if (!rx_iso || !rx_iso_used_reg) begin
                  rx_iso_used_next = rx_iso;
                  rx_cnt_next = UEF_BYTE_ZERO;
                  rx_ovf_next = 1'b0;
                  state_next = UEF_RX_DATA;
               end
            end
         end
         UEF_TX_SEND: begin
            if (tx_cnt_reg == tx_len_reg) begin
               state_next = tx_iso ? UEF_IDLE : UEF_TX_WAIT_HS;
            end else if (tx_accept) begin
               tx_cnt_next = tx_cnt_reg + LEN_ONE;
               tx_rp_next = tx_rp_reg + PTR_ONE;
            end
         end
         UEF_TX_WAIT_HS: begin
            if (hs_in_valid) begin
               state_next = UEF_IDLE;
               tx_done_set = 1'b1;
               status_next[UEF_ST_TX_ACK] = hs_in_ack;
               status_next[UEF_ST_TX_ERR] = !hs_in_ack;
               if (hs_in_ack) begin
                  tx_seq_next = !tx_seq_reg;
                  status_next[UEF_ST_TX_READY] = 1'b0;
                  if (tx_auto) begin
                     tx_rm_next = tx_rp_reg;
                  end
               end else if (tx_auto) begin
                  // packet stays armed for the next IN
                  tx_rp_next = tx_rm_reg;
               end
            end
         end
         UEF_RX_DATA: begin
            if (rx_valid) begin
               if (rx_room) begin
                  rx_mem_we = 1'b1;
                  rx_wp_next = rx_wp_reg + PTR_ONE;
                  rx_cnt_next = rx_cnt_reg + LEN_ONE;
               end else begin
                  rx_ovf_next = 1'b1;
               end
            end else if (rx_end) begin
               state_next = UEF_IDLE;
               rx_len_next = rx_cnt_reg;
               if (rx_iso) begin
                  rx_iso_pend_next = 1'b1;
                  rx_iso_good_next = rx_good && !rx_ovf_reg;
               end else begin
                  rx_done_set = 1'b1;
                  status_next[UEF_ST_RX_OVF] = rx_ovf_reg;
                  if (rx_good && !rx_ovf_reg && (rx_seq == rx_exp_reg)) begin
                     hs_ack_next = 1'b1;
                     rx_exp_next = !rx_exp_reg;
                     status_next[UEF_ST_RX_ACK] = 1'b1;
                     status_next[UEF_ST_RX_ERR] = 1'b0;
                     if (rx_auto) begin
                        rx_wm_next = rx_wp_reg;
                     end
                  end else begin
                     // repeated packet is acked but dropped; overflow asks for resend
                     hs_ack_next = rx_good && !rx_ovf_reg;
                     hs_nak_next = rx_good && rx_ovf_reg;
                     status_next[UEF_ST_RX_ACK] = 1'b0;
                     status_next[UEF_ST_RX_ERR] = !rx_good || rx_ovf_reg;
                     if (rx_auto) begin
                        rx_wp_next = rx_wm_reg;
                     end
                  end
               end
            end
         end
         default: state_next = UEF_IDLE;
      endcase

      // hardware set wins over a firmware clear in the same cycle
      if (tx_done_set) begin
         status_next[UEF_ST_TX_DONE] = 1'b1;
      end
      if (rx_done_set) begin
         status_next[UEF_ST_RX_DONE] = 1'b1;
      end
      tx_data_next = tx_mem[tx_rp_next[PW-2:0]];
   end

   always_ff @(posedge clk) begin
      if (tx_mem_we) begin
         tx_mem[tx_wp_reg[PW-2:0]] <= reg_wdata;
      end
      if (rx_mem_we) begin
         rx_mem[rx_wp_reg[PW-2:0]] <= rx_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= UEF_IDLE;
         tx_ctl_reg <= UEF_CTL_RESET;
         rx_ctl_reg <= UEF_CTL_RESET;
         tx_wp_reg <= '0;
         tx_rm_reg <= '0;
         tx_rp_reg <= '0;
         rx_wp_reg <= '0;
         rx_wm_reg <= '0;
         rx_rp_reg <= '0;
         tx_len_reg <= UEF_BYTE_ZERO;
         tx_cnt_reg <= UEF_BYTE_ZERO;
         rx_cnt_reg <= UEF_BYTE_ZERO;
         rx_len_reg <= UEF_BYTE_ZERO;
         status_reg <= UEF_BYTE_ZERO;
         tx_seq_reg <= 1'b0;
         rx_exp_reg <= 1'b0;
         tx_iso_used_reg <= 1'b0;
         rx_iso_used_reg <= 1'b0;
         tx_iso_pend_reg <= 1'b0;
         rx_iso_pend_reg <= 1'b0;
         rx_iso_good_reg <= 1'b0;
         rx_ovf_reg <= 1'b0;
         tx_data_reg <= UEF_BYTE_ZERO;
         rdata_reg <= UEF_BYTE_ZERO;
         hs_ack_reg <= 1'b0;
         hs_nak_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tx_ctl_reg <= tx_ctl_next;
         rx_ctl_reg <= rx_ctl_next;
         tx_wp_reg <= tx_wp_next;
         tx_rm_reg <= tx_rm_next;
         tx_rp_reg <= tx_rp_next;
         rx_wp_reg <= rx_wp_next;
         rx_wm_reg <= rx_wm_next;
         rx_rp_reg <= rx_rp_next;
         tx_len_reg <= tx_len_next;
         tx_cnt_reg <= tx_cnt_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_len_reg <= rx_len_next;
         status_reg <= status_next;
         tx_seq_reg <= tx_seq_next;
         rx_exp_reg <= rx_exp_next;
         tx_iso_used_reg <= tx_iso_used_next;
         rx_iso_used_reg <= rx_iso_used_next;
         tx_iso_pend_reg <= tx_iso_pend_next;
         rx_iso_pend_reg <= rx_iso_pend_next;
         rx_iso_good_reg <= rx_iso_good_next;
         rx_ovf_reg <= rx_ovf_next;
         tx_data_reg <= tx_data_next;
         rdata_reg <= rdata_next;
         hs_ack_reg <= hs_ack_next;
         hs_nak_reg <= hs_nak_next;
      end
   end
endmodule

// File: rtl/uef_pkg.sv
// constants shared by the endpoint transfer logic
package uef_pkg;
   // register indices on the plain register port
   localparam logic [2:0] UEF_REG_TX_CTRL = 3'h0;
   localparam logic [2:0] UEF_REG_RX_CTRL = 3'h1;
   localparam logic [2:0] UEF_REG_TX_DATA = 3'h2;
   localparam logic [2:0] UEF_REG_TX_LEN = 3'h3;
   localparam logic [2:0] UEF_REG_RX_DATA = 3'h4;
   localparam logic [2:0] UEF_REG_STATUS = 3'h5;
   localparam logic [2:0] UEF_REG_RX_LEN = 3'h6;
   // control register fields, same layout for both directions
   localparam int UEF_CTL_ISO = 3;
   localparam int UEF_CTL_AUTO = 2;
   localparam int UEF_CTL_ADVANCE = 1;
   localparam int UEF_CTL_REWIND = 0;
   // status register fields
   localparam int UEF_ST_TX_DONE = 0;
   localparam int UEF_ST_RX_DONE = 1;
   localparam int UEF_ST_TX_ACK = 2;
   localparam int UEF_ST_TX_ERR = 3;
   localparam int UEF_ST_RX_ACK = 4;
   localparam int UEF_ST_RX_ERR = 5;
   localparam int UEF_ST_RX_OVF = 6;
   localparam int UEF_ST_TX_READY = 7;
   // reset values
   localparam logic [3:0] UEF_CTL_RESET = 4'h4;
   localparam logic [7:0] UEF_BYTE_ZERO = 8'h00;
   // token kinds from the serial engine
   localparam logic [1:0] UEF_TOK_IN = 2'h0;
   localparam logic [1:0] UEF_TOK_OUT = 2'h1;
   localparam logic [1:0] UEF_TOK_SOF = 2'h2;
   // nominal frame period
   localparam real UEF_FRAME_MS = 1.0;
   typedef enum logic [1:0] {
      UEF_IDLE,
      UEF_TX_SEND,
      UEF_TX_WAIT_HS,
      UEF_RX_DATA
   } uef_state_t;
endpackage

// File: test/tb_top.sv
// self-checking bench for the endpoint transfer engine
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import uef_pkg::*;
   logic clk, sys_rst, reg_wr, reg_rd, slow, ok, sq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data, v, m;
   logic [1:0] tok_kind;
   logic tok_valid, tok_pid_ok, tx_valid, tx_accept, tx_eop, tx_seq, hs_in_valid, hs_in_ack;
   logic rx_valid, rx_end, rx_good, rx_seq, hs_out_ack, hs_out_nak;
   logic [31:0] seed = 32'h0000f35b;
   logic [7:0] pkt[$];
   int bad_count, n_checks, cycles, n;
   uef_endpoint DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid),
      .tok_pid_ok(tok_pid_ok), .tok_kind(tok_kind), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_accept(tx_accept), .tx_eop(tx_eop), .tx_seq(tx_seq), .hs_in_valid(hs_in_valid),
      .hs_in_ack(hs_in_ack), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
      .rx_good(rx_good), .rx_seq(rx_seq), .hs_out_ack(hs_out_ack), .hs_out_nak(hs_out_nak));
   uef_host_model host (.clk(clk), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_eop(tx_eop), .hs_out_ack(hs_out_ack), .hs_out_nak(hs_out_nak), .tok_kind(tok_kind),
      .rx_data(rx_data), .tok_valid(tok_valid), .tok_pid_ok(tok_pid_ok), .tx_accept(tx_accept),
      .hs_in_valid(hs_in_valid), .hs_in_ack(hs_in_ack), .rx_valid(rx_valid), .rx_end(rx_end),
      .rx_good(rx_good), .rx_seq(rx_seq));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] bm(input int b);
      return 8'h01 << b;
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic fill(input int len);
      pkt = {};
      repeat (len) pkt.push_back(8'(xs()));
   endtask
   task automatic load(input int len);
      fill(len);
      foreach (pkt[i]) wr(UEF_REG_TX_DATA, pkt[i]);
      wr(UEF_REG_TX_LEN, 8'(len));
   endtask
   task automatic do_in(input logic a, input logic hs);
      int e;
      e = host.n_eop;
      host.got = {};
      host.token(UEF_TOK_IN, 1'b1);
      repeat (40) if (host.n_eop == e) @(posedge clk);
      chk("eop", 8'(host.n_eop - e), 8'h01);
      chk("count", 8'(host.got.size()), 8'(pkt.size()));
      foreach (pkt[i]) chk("byte", host.got[i], pkt[i]);
      if (hs) host.hshake(a);
   endtask
   task automatic chk_st(input logic [7:0] mk, input logic [7:0] e);
      logic [7:0] s;
      rd(UEF_REG_STATUS, s);
      chk("status", s & mk, e);
      wr(UEF_REG_STATUS, 8'h03);
   endtask
   task automatic drain(input logic a);
      logic [7:0] d;
      if (a) begin
         rd(UEF_REG_RX_LEN, d);
         chk("rx len", d, 8'(pkt.size()));
         foreach (pkt[i]) begin
            rd(UEF_REG_RX_DATA, d);
            chk("rx byte", d, pkt[i]);
         end
      end
      rd(UEF_REG_RX_DATA, d);
      chk("rx empty", d, UEF_BYTE_ZERO);
   endtask
   initial begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, slow} = '0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rd(UEF_REG_TX_CTRL, v);
      chk("tx ctrl", v, 8'(UEF_CTL_RESET));
      rd(UEF_REG_RX_CTRL, v);
      chk("rx ctrl", v, 8'(UEF_CTL_RESET));
      wr(3'h7, 8'hff);
      rd(3'h7, v);
      chk("unmapped", v, UEF_BYTE_ZERO);
      wr(UEF_REG_TX_CTRL, 8'h03);
      rd(UEF_REG_TX_CTRL, v);
      chk("manual ctrl", v, 8'h00);
      wr(UEF_REG_TX_CTRL, 8'h04);
      $display("test registers done");
      n = host.n_nak;
      host.token(UEF_TOK_IN, 1'b1);
      repeat (3) @(posedge clk);
      chk("nak", 8'(host.n_nak - n), 8'h01);
      load(2);
      host.token(UEF_TOK_IN, 1'b0);
      repeat (3) @(posedge clk);
      chk("bad pid", 8'(host.n_nak + host.n_eop - n), 8'h01);
      $display("test nak done");
      ok = 1'b0;
      sq = 1'b0;
      // failed packets are retried without reloading
      for (int i = 0; i < 6; i++) begin
         if (ok) load(1 + xs() % 4);
         ok = (i < 2) ? (i == 0) : (i == 5) | 1'(xs());
         slow <= 1'(xs());
         do_in(ok, 1'b1);
         m = bm(UEF_ST_TX_DONE) | bm(UEF_ST_TX_READY) | bm(ok ? UEF_ST_TX_ACK : UEF_ST_TX_ERR);
         v = ok ? bm(UEF_ST_TX_ACK) : bm(UEF_ST_TX_ERR) | bm(UEF_ST_TX_READY);
         chk_st(m, bm(UEF_ST_TX_DONE) | v);
         sq = sq ^ ok;
         chk("tx seq", 8'(tx_seq), 8'(sq));
      end
      $display("test transmit done");
      // good, duplicate, bad crc, good
      for (int i = 0; i < 4; i++) begin
         ok = (i != 2);
         fill(1 + xs() % 4);
         n = host.n_ack;
         host.send(pkt, ok, i > 1);
         repeat (3) @(posedge clk);
         chk("rx hs", 8'(host.n_ack - n), 8'(ok));
         ok = (i == 0 || i == 3);
         m = bm(UEF_ST_RX_DONE) | bm(UEF_ST_RX_ACK) | bm(UEF_ST_RX_ERR);
         v = (i == 2) ? bm(UEF_ST_RX_ERR) : ok ? bm(UEF_ST_RX_ACK) : 8'h00;
         chk_st(m, bm(UEF_ST_RX_DONE) | v);
         drain(ok);
      end
      $display("test receive done");
      wr(UEF_REG_TX_CTRL, 8'h0c);
      wr(UEF_REG_RX_CTRL, 8'h0c);
      load(3);
      do_in(1'b0, 1'b0);
      n = host.n_eop;
      host.token(UEF_TOK_IN, 1'b1);
      repeat (4) @(posedge clk);
      chk("iso twice", 8'(host.n_eop - n), 8'h00);
      chk_st(bm(UEF_ST_TX_DONE), 8'h00);
      fill(2);
      n = host.n_ack + host.n_nak;
      host.send(pkt, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      chk("iso hs", 8'(host.n_ack + host.n_nak - n), 8'h00);
      chk_st(bm(UEF_ST_RX_DONE), 8'h00);
      host.token(UEF_TOK_SOF, 1'b1);
      repeat (3) @(posedge clk);
      m = bm(UEF_ST_TX_ACK) | bm(UEF_ST_TX_READY) | bm(UEF_ST_RX_ACK);
      chk_st(m, bm(UEF_ST_TX_ACK) | bm(UEF_ST_RX_ACK));
      drain(1'b1);
      load(1);
      do_in(1'b0, 1'b0);
      $display("test iso done");
      summarize();
   end
endmodule

// File: test/uef_endpoint_props.sv
// port assertions for the endpoint transfer engine
module uef_endpoint_props
#(
   parameter int DEPTH = 64
) (
   // clock, reset, register port, tx and rx data bytes
   input wire logic clk, sys_rst, reg_wr, reg_rd,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data,
   // link signals
   input wire logic [1:0] tok_kind,
   input wire logic tok_valid, tok_pid_ok, tx_valid, tx_accept, tx_eop, tx_seq,
   input wire logic hs_in_valid, hs_in_ack, rx_valid, rx_end, rx_good, rx_seq,
   input wire logic hs_out_ack, hs_out_nak
);
   timeunit 1ns;
   timeprecision 1ns;
   import uef_pkg::*;
   logic tx_iso_reg, tx_iso_next, rx_iso_reg, rx_iso_next;
   // shadow of the iso select bits
   always_comb begin
      tx_iso_next = (reg_wr && reg_addr == UEF_REG_TX_CTRL) ? reg_wdata[UEF_CTL_ISO] : tx_iso_reg;
      rx_iso_next = (reg_wr && reg_addr == UEF_REG_RX_CTRL) ? reg_wdata[UEF_CTL_ISO] : rx_iso_reg;
   end
   always_ff @(posedge clk) begin
      tx_iso_reg <= sys_rst ? UEF_CTL_RESET[UEF_CTL_ISO] : tx_iso_next;
      rx_iso_reg <= sys_rst ? UEF_CTL_RESET[UEF_CTL_ISO] : rx_iso_next;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_in_tok;
      tok_valid && tok_pid_ok && tok_kind == UEF_TOK_IN;
   endsequence
   sequence s_out_end;
      rx_end && rx_good && !rx_iso_reg;
   endsequence
   a_in_answer: assert property (
      s_in_tok ##0 !tx_iso_reg |=> tx_valid || tx_eop || hs_out_nak)
      else $error("in token unanswered");
   a_nak_cause: assert property (
      hs_out_nak |-> $past(tok_valid && tok_kind == UEF_TOK_IN) || $past(rx_end))
      else $error("nak without cause");
   a_ack_cause: assert property (
      hs_out_ack |-> $past(rx_end && rx_good && !rx_iso_reg))
      else $error("ack without good non-iso packet");
   a_out_hs: assert property (
      s_out_end |=> hs_out_ack || hs_out_nak)
      else $error("out packet without handshake");
   a_eop_cause: assert property (
      tx_eop |-> !tx_valid && ($past(tx_valid && tx_accept) || $past(tok_valid)))
      else $error("end of packet out of place");
   a_tx_hold: assert property (
      tx_valid && !tx_accept |=> tx_valid && $stable(tx_data))
      else $error("tx byte not held");
   a_seq_flip: assert property (
      hs_in_valid && hs_in_ack && !tx_iso_reg |=> tx_seq != $past(tx_seq))
      else $error("sequence bit not toggled");
   a_seq_keep: assert property (
      hs_in_valid && !hs_in_ack |=> $stable(tx_seq))
      else $error("sequence bit moved on failure");
endmodule

bind uef_endpoint uef_endpoint_props #(.DEPTH(DEPTH)) u_props (
   .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_data(tx_data), .rx_data(rx_data),
   .tok_kind(tok_kind), .tok_valid(tok_valid), .tok_pid_ok(tok_pid_ok), .tx_valid(tx_valid),
   .tx_accept(tx_accept), .tx_eop(tx_eop), .tx_seq(tx_seq), .hs_in_valid(hs_in_valid),
   .hs_in_ack(hs_in_ack), .rx_valid(rx_valid), .rx_end(rx_end), .rx_good(rx_good),
   .rx_seq(rx_seq), .hs_out_ack(hs_out_ack), .hs_out_nak(hs_out_nak)
);

// File: test/uef_host_model.sv
// host side model: tokens, byte sink, handshakes, packet source
module uef_host_model (
   // clock and sink pacing
   input wire logic clk, slow,
   // from the endpoint
   input wire logic [7:0] tx_data,
   input wire logic tx_valid, tx_eop, hs_out_ack, hs_out_nak,
   // to the endpoint
   output logic [1:0] tok_kind,
   output logic [7:0] rx_data,
   output logic tok_valid, tok_pid_ok, tx_accept, hs_in_valid, hs_in_ack,
   output logic rx_valid, rx_end, rx_good, rx_seq
);
   timeunit 1ns;
   timeprecision 1ns;
   import uef_pkg::*;
   logic [7:0] got[$];
   int n_eop, n_ack, n_nak;
   initial begin
      {tok_kind, rx_data, tok_valid, tok_pid_ok, tx_accept} = '0;
      {hs_in_valid, hs_in_ack, rx_valid, rx_end, rx_good, rx_seq} = '0;
   end
   // sink stalls every other cycle when slow
   always @(posedge clk) begin
      tx_accept <= slow ? !tx_accept : 1'b1;
      if (tx_valid && tx_accept) got.push_back(tx_data);
      if (tx_eop) n_eop++;
      if (hs_out_ack) n_ack++;
      if (hs_out_nak) n_nak++;
   end
   task automatic token(input logic [1:0] k, input logic ok);
      @(posedge clk);
      tok_valid <= 1'b1;
      tok_pid_ok <= ok;
      tok_kind <= k;
      @(posedge clk);
      tok_valid <= 1'b0;
      tok_kind <= ~k;
   endtask
   task automatic hshake(input logic ack);
      @(posedge clk);
      hs_in_valid <= 1'b1;
      hs_in_ack <= ack;
      @(posedge clk);
      hs_in_valid <= 1'b0;
      hs_in_ack <= ~ack;
   endtask
   task automatic send(input logic [7:0] q[$], input logic good, input logic seq);
      token(UEF_TOK_OUT, 1'b1);
      foreach (q[i]) begin
         rx_valid <= 1'b1;
         rx_data <= q[i];
         @(posedge clk);
      end
      rx_valid <= 1'b0;
      rx_end <= 1'b1;
      rx_good <= good;
      rx_seq <= seq;
      @(posedge clk);
      rx_end <= 1'b0;
      rx_data <= ~rx_data;
      rx_good <= ~good;
      rx_seq <= ~seq;
   endtask
endmodule
